// ===== rtl/reset_cause_pkg.sv
// Constants, field layout and types for the reset cause and enable register
package reset_cause_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] RESET_CAUSE_ENABLE_ADDR = 8'hef;

    // ------------------------------------------------------------------
    // Field positions inside the register
    // ------------------------------------------------------------------
    localparam int unsigned USB_BIT    = 7;
    localparam int unsigned PROGRAM_MEMORY_ERROR_FLAG_BIT = 6;
    localparam int unsigned COMP_BIT   = 5;
    localparam int unsigned SW_BIT     = 4;
    localparam int unsigned WDT_BIT    = 3;
    localparam int unsigned MCD_BIT    = 2;
    localparam int unsigned POR_BIT    = 1;
    localparam int unsigned PIN_BIT    = 0;

    // ------------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------------
    localparam logic [7:0] POR_CAUSE_VALUE   = 8'h02;
    localparam logic [7:0] READ_IDLE_VALUE   = 8'h00;
    localparam logic [2:0] HOLD_CYCLES       = 3'h4;
    localparam logic       USB_EN_RESET      = 1'b0;
    localparam logic       COMP_EN_RESET     = 1'b0;
    localparam logic       MCD_EN_RESET      = 1'b0;
    localparam logic       VDD_EN_RESET      = 1'b1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic usb;
        logic program_memory_error_flag;
        logic comp;
        logic sw;
        logic wdt;
        logic missing_clock_detector;
        logic por;
        logic pin;
    } reset_cause_s;

    typedef enum logic [0:0] {
        ST_RUN  = 1'b0,
        ST_HOLD = 1'b1
    } seq_state_e;

endpackage : reset_cause_pkg

// ===== rtl/reset_cause_enable.sv
// Reset cause recorder, reset source enables and system reset sequencer
`timescale 1ns/1ns

module reset_cause_enable
    import reset_cause_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       usb_bus_reset,
    input  wire logic       supply_detect,
    input  wire logic       supply_detect_edge_polarity,
    input  wire logic       program_memory_error,
    input  wire logic       comparator_out,
    input  wire logic       watchdog_overflow,
    input  wire logic       missing_clock_timeout,
    input  wire logic       supply_below_threshold,
    input  wire logic       ext_reset_n,
    output logic      [7:0] sfr_rdata,
    output logic            system_reset,
    output logic            missing_clock_detector_enable,
    output logic            supply_monitor_reset_enable
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    seq_state_e   state_ff;
    logic [2:0]   hold_cnt_ff;
    logic         system_reset_ff;
    reset_cause_s cause_ff;
    reset_cause_s nxt_cause;
    logic         usb_en_ff;
    logic         comp_en_ff;
    logic         mcd_en_ff;
    logic         vdd_en_ff;
    logic         supply_detect_prev_ff;
    logic [7:0]   sfr_rdata_ff;
    logic         reg_hit;
    logic         reg_write;
    logic         sw_force;
    logic         vbus_edge;
    logic         trig;

    // Register decode; writes only count while the system runs
    assign reg_hit   = (sfr_addr == RESET_CAUSE_ENABLE_ADDR);
    assign reg_write = sfr_wr && reg_hit && (state_ff == ST_RUN);
    assign sw_force  = reg_write && sfr_wdata[SW_BIT];

    assign vbus_edge = supply_detect_edge_polarity ? (supply_detect && !supply_detect_prev_ff)
                                                   : (!supply_detect && supply_detect_prev_ff);

    // Previous supply detect level for edge detection
    // Reset loads the live level, so a pin already high is not taken for an edge
    always_ff @(posedge mclk) begin
        if (srst) begin
            supply_detect_prev_ff <= supply_detect;
        end else begin
            supply_detect_prev_ff <= supply_detect;
        end
    end

    // ------------------------------------------------------------------
    // Cause selection
    // ------------------------------------------------------------------
    // Fixed priority: only one flag may be set, so simultaneous events
    // are resolved in favour of the more fundamental source.
    always_comb begin
        nxt_cause = '0;
        trig      = 1'b1;
        if (!ext_reset_n) begin
            nxt_cause.pin = 1'b1;
        end else if (vdd_en_ff && supply_below_threshold) begin
            nxt_cause.por = 1'b1;
        end else if (mcd_en_ff && missing_clock_timeout) begin
            nxt_cause.missing_clock_detector = 1'b1;
        end else if (program_memory_error) begin
            nxt_cause.program_memory_error_flag = 1'b1;
        end else if (watchdog_overflow) begin
            nxt_cause.wdt = 1'b1;
        end else if (comp_en_ff && !comparator_out) begin
            nxt_cause.comp = 1'b1;
        end else if (usb_en_ff && (usb_bus_reset || vbus_edge)) begin
            nxt_cause.usb = 1'b1;
        end else if (sw_force) begin
            nxt_cause.sw = 1'b1;
        end else begin
            trig = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------------
    // internal resets only drive system_reset, never the pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff        <= ST_HOLD;
            hold_cnt_ff     <= HOLD_CYCLES - 3'h1;
            system_reset_ff <= 1'b1;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (trig) begin
                        state_ff        <= ST_HOLD;
                        hold_cnt_ff     <= HOLD_CYCLES - 3'h1;
                        system_reset_ff <= 1'b1;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt_ff == 3'h0) begin
                        state_ff        <= ST_RUN;
                        system_reset_ff <= 1'b0;
                    end else begin
                        hold_cnt_ff <= hold_cnt_ff - 3'h1;
                    end
                end
                default: begin
                    state_ff        <= ST_RUN;
                    system_reset_ff <= 1'b0;
                end
            endcase
        end
    end

    // one-hot cause capture
    // Events during the hold are ignored so the first cause is kept.
    always_ff @(posedge mclk) begin
        if (srst) begin
            cause_ff <= reset_cause_s'(POR_CAUSE_VALUE);
        end else if (state_ff == ST_RUN && trig) begin
            cause_ff <= nxt_cause;
        end
    end

    // ------------------------------------------------------------------
    // Source enables
    // ------------------------------------------------------------------
    // enables follow each direct write made while running, except a write in a cycle that starts a reset
    // A reset returns them to defaults, so a stale enable cannot re-fire.
    always_ff @(posedge mclk) begin
        if (srst || (state_ff == ST_RUN && trig)) begin
            usb_en_ff  <= USB_EN_RESET;
            comp_en_ff <= COMP_EN_RESET;
            mcd_en_ff  <= MCD_EN_RESET;
            vdd_en_ff  <= VDD_EN_RESET;
        end else if (reg_write) begin
            usb_en_ff  <= sfr_wdata[USB_BIT];
            comp_en_ff <= sfr_wdata[COMP_BIT];
            mcd_en_ff  <= sfr_wdata[MCD_BIT];
            vdd_en_ff  <= sfr_wdata[POR_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sfr_rdata_ff <= READ_IDLE_VALUE;
        end else if (sfr_rd && reg_hit) begin
            sfr_rdata_ff <= cause_ff;
        end else begin
            sfr_rdata_ff <= READ_IDLE_VALUE;
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata                     = sfr_rdata_ff;
    assign system_reset                  = system_reset_ff;
    assign missing_clock_detector_enable = mcd_en_ff;
    assign supply_monitor_reset_enable   = vdd_en_ff;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_sw_force_reset: assert property (
        sw_force |=> system_reset_ff && $onehot(cause_ff))
        else $error("software force did not start a reset");

    a_hold_length: assert property (
        (state_ff == ST_RUN && trig) |=> system_reset_ff [*4] ##1 !system_reset_ff)
        else $error("reset hold length wrong");

    a_pin_cause: assert property (
        (state_ff == ST_RUN && !ext_reset_n) |=> cause_ff.pin && system_reset_ff)
        else $error("pin reset not recorded");

    a_program_memory_error_flag_source: assert property (
        $rose(cause_ff.program_memory_error_flag) |-> $past(program_memory_error))
        else $error("memory error flag set without event");

    a_wdt_source: assert property (
        $rose(cause_ff.wdt) |-> $past(watchdog_overflow))
        else $error("watchdog flag set without overflow");

    a_comp_gate: assert property (
        $rose(cause_ff.comp) |-> $past(comp_en_ff && !comparator_out))
        else $error("comparator reset without enable");

    a_mcd_gate: assert property (
        $rose(cause_ff.missing_clock_detector) |-> $past(mcd_en_ff && missing_clock_timeout))
        else $error("missing clock reset without enable");

    a_mcd_disable: assert property (
        (reg_write && !sfr_wdata[MCD_BIT]) |=> !mcd_en_ff)
        else $error("missing clock enable not cleared");

    a_read_value: assert property (
        (sfr_rd && reg_hit) |=> sfr_rdata_ff == $past(cause_ff))
        else $error("read data differs from causes");

    a_one_cause: assert property (
        $onehot(cause_ff))
        else $error("cause register not one-hot");

    a_usb_gate: assert property (
        $rose(cause_ff.usb) |-> $past(usb_en_ff && (usb_bus_reset || vbus_edge)))
        else $error("usb reset without enable or event");

    c_sw_reset: cover property (sw_force ##1 system_reset_ff);
    c_usb_reset: cover property ($rose(cause_ff.usb));
    c_monitor_reset: cover property (state_ff == ST_RUN ##1 cause_ff.por && system_reset_ff);

endmodule : reset_cause_enable

// ===== sim/tb.sv
// Self-checking bench for the reset cause and enable register
`timescale 1ns/1ns
module tb;
    import reset_cause_pkg::*;
    logic       mclk, srst, sfr_wr, sfr_rd, usb_bus_reset, supply_detect;
    logic       program_memory_error, comparator_out, watchdog_overflow;
    logic       missing_clock_timeout, supply_below_threshold, ext_reset_n;
    logic       system_reset, mcd_en, mon_en, supply_pol;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
    int         err_total, compares, cycles, n;

    reset_cause_enable dut (.mclk(mclk), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .usb_bus_reset(usb_bus_reset),
        .supply_detect(supply_detect), .supply_detect_edge_polarity(supply_pol),
        .program_memory_error(program_memory_error), .comparator_out(comparator_out),
        .watchdog_overflow(watchdog_overflow), .missing_clock_timeout(missing_clock_timeout),
        .supply_below_threshold(supply_below_threshold), .ext_reset_n(ext_reset_n),
        .sfr_rdata(sfr_rdata), .system_reset(system_reset),
        .missing_clock_detector_enable(mcd_en), .supply_monitor_reset_enable(mon_en));

    // ----------------------------------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic print_verdict();
        if (err_total == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            $display("ERROR at %0t: run timed out", $time);
            print_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Register access and source stimulus
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] v);
        @(posedge mclk);
        sfr_addr  <= RESET_CAUSE_ENABLE_ADDR;
        sfr_wdata <= v;
        sfr_wr    <= 1'b1;
        @(posedge mclk);
        sfr_wr    <= 1'b0;
        #1;
    endtask : wr

    // Read data is valid for one cycle only, so sample right after the edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        sfr_addr <= a;
        sfr_rd   <= 1'b1;
        @(posedge mclk);
        sfr_rd   <= 1'b0;
        #1 v = sfr_rdata;
    endtask : rd

    // Count hold cycles, bounded so a stuck reset cannot hang the bench
    task automatic wait_run(output int k);
        k = 0;
        while (system_reset === 1'b1 && k < 20) begin
            @(posedge mclk);
            #1 k++;
        end
    endtask : wait_run

    // Mask uses the cause layout; comparator and pin are active low
    task automatic fire(input logic [7:0] m);
        if (m != 8'h00) begin
            @(posedge mclk);
            {usb_bus_reset, program_memory_error, watchdog_overflow} <= {m[7], m[6], m[3]};
            {missing_clock_timeout, supply_below_threshold} <= m[2:1];
            comparator_out <= ~m[5];
            ext_reset_n    <= ~m[0];
            @(posedge mclk);
            {usb_bus_reset, program_memory_error, watchdog_overflow} <= 3'h0;
            {missing_clock_timeout, supply_below_threshold} <= 2'h0;
            {comparator_out, ext_reset_n} <= 2'h3;
            #1;
        end
    endtask : fire

    task automatic case_run(input logic [7:0] en, m, exp, input int hold);
        wr(en);
        fire(m);
        wait_run(n);
        check(n[7:0], hold[7:0]);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, exp);
    endtask : case_run

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {err_total, compares, cycles} = '0;
        {srst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {1'b1, 18'h0};
        {usb_bus_reset, supply_detect, program_memory_error, watchdog_overflow} = 4'h0;
        {missing_clock_timeout, supply_below_threshold} = 2'h0;
        {comparator_out, ext_reset_n} = 2'h3;
        supply_pol = 1'b1;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1 wait_run(n);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, POR_CAUSE_VALUE);
        check({6'h00, mcd_en, mon_en}, 8'h01);
        rd(8'he0, d);
        check(d, READ_IDLE_VALUE);
        wr(8'h04);
        check({6'h00, mcd_en, mon_en}, 8'h02);
        wr(8'h00);
        check({6'h00, mcd_en, mon_en}, 8'h00);
        // Monitor stays off while the supply is low, so no reset may follow
        case_run(8'h00, 8'h02, 8'h02, 0);
        case_run(8'h00, 8'h01, 8'h01, 4);
        case_run(8'h49, 8'h40, 8'h40, 4);
        case_run(8'h00, 8'h08, 8'h08, 4);
        case_run(8'h20, 8'h20, 8'h20, 4);
        case_run(8'h80, 8'h80, 8'h80, 4);
        case_run(8'h04, 8'h04, 8'h04, 4);
        case_run(8'h02, 8'h02, 8'h02, 4);
        case_run(8'h10, 8'h00, 8'h10, 4);
        case_run(8'h00, 8'h09, 8'h01, 4);
        case_run(8'h00, 8'h20, 8'h01, 0);
        case_run(8'h00, 8'h04, 8'h01, 0);
        case_run(8'h00, 8'h80, 8'h01, 0);
        // Supply-detect rising edge with the USB source enabled
        wr(8'h80);
        @(posedge mclk);
        supply_detect <= 1'b1;
        @(posedge mclk);
        #1 wait_run(n);
        check(n[7:0], 8'h04);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, 8'h80);
        // A write landing inside the hold must be dropped
        wr(8'h14);
        wr(8'h04);
        wait_run(n);
        check({6'h00, mcd_en, mon_en}, 8'h01);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, 8'h10);
        // Falling polarity: only a falling supply-detect edge may fire
        @(posedge mclk);
        supply_pol <= 1'b0;
        wr(8'h80);
        @(posedge mclk);
        supply_detect <= 1'b0;
        @(posedge mclk);
        #1 wait_run(n);
        check(n[7:0], 8'h04);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, 8'h80);
        // Mid-run power-on reset; three hold edges remain after the first one
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1 wait_run(n);
        check(n[7:0], 8'h03);
        rd(RESET_CAUSE_ENABLE_ADDR, d);
        check(d, POR_CAUSE_VALUE);
        check({6'h00, mcd_en, mon_en}, 8'h01);
        print_verdict();
    end
endmodule : tb
